// ==== tcfe_pkg.sv ====
package tcfe_pkg;
	localparam logic [7:0] TCFE_CTRL_OFS = 8'h00;
	localparam logic [7:0] TCFE_FLAG_OFS = 8'h10;
	localparam logic [7:0] TCFE_EVGEN_OFS = 8'h14;
	localparam logic [7:0] TCFE_MODE_OFS = 8'h18;
	localparam logic [7:0] TCFE_CMP1_OFS = 8'h34;
	localparam logic [7:0] TCFE_CMP2_OFS = 8'h38;

	// Control register fields
	localparam int TCFE_CTRL_UPDATE_DISABLE = 1;
	localparam int TCFE_CTRL_URS = 2;
	localparam int TCFE_CTRL_LOCK_LO = 8;
	localparam logic [1:0] TCFE_LOCK_FULL = 2'h3;

	// Flag and event-generation fields share positions
	localparam int TCFE_F_UPD = 0;
	localparam int TCFE_F_CC0 = 1;
	localparam int TCFE_F_TRG = 6;
	localparam int TCFE_F_OVR0 = 9;
	localparam logic [15:0] TCFE_FLAG_MASK = 16'h1E5F;

	// Per-channel byte of the mode control register
	localparam int TCFE_M_DIR_LO = 0;
	localparam int TCFE_M_FE = 2;
	localparam int TCFE_M_PE = 3;
	localparam int TCFE_M_MODE_LO = 4;
	localparam int TCFE_M_CE = 7;
	localparam int TCFE_M_CH_W = 8;
	localparam logic [7:0] TCFE_M_LOCKED = 8'h78;
	localparam logic [1:0] TCFE_DIR_OUT = 2'h0;

	typedef enum logic [2:0] {
		TCFE_OM_FROZEN = 3'h0,
		TCFE_OM_SET = 3'h1,
		TCFE_OM_CLR = 3'h2,
		TCFE_OM_TOGGLE = 3'h3,
		TCFE_OM_LOW = 3'h4,
		TCFE_OM_HIGH = 3'h5,
		TCFE_OM_PWM1 = 3'h6,
		TCFE_OM_PWM2 = 3'h7
	} tcfe_omode_t;

	// Trigger-to-output latencies in clock cycles
	localparam int TCFE_FAST_DLY_CYC = 3;
	localparam int TCFE_NORM_DLY_CYC = 5;

	typedef struct packed {
		logic count_down;
		logic center_aligned;
		logic rep_wrap;
		logic trig_reinit;
		logic gating_mode;
	} tcfe_core_t;
endpackage

// ==== tcfe_top.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Capture while channel flag set raises its recapture flag; cleared by writing zero.
// (R2) Trigger flag set on trigger edge; either edge in gating mode.
// (R3) Output channel: flag set on counter equal compare, not center-aligned.
// (R4) Input channel: flag set on capture; cleared by zero write or register read.
// (R5) Repetition wrap raises update event and flag unless updates disabled.
// (R6) Forced update or software reinit sets update flag when source is all.
// (R7) Trigger reinit of counter sets update flag when source is all.
// (R8) Trigger-generation bit makes trigger event and flag; self-clears.
// (R9) Channel generation bit in output mode sets channel flag; self-clears.
// (R10) Generation bit in input mode captures counter, sets flag, maybe recapture.
// (R11) Update-generation bit reinitialises counter, clears prescaler, raises update.
// (R12) Forced update clears counter, or loads reload value when counting down.
// (R13) Clear enable drives reference low while external trigger high.
// (R14) Modes 000 to 011: frozen, set, clear, toggle on match.
// (R15) Mode 100 forces reference low, mode 101 forces it high.
// (R16) PWM1: active below compare counting up, inactive above counting down.
// (R17) PWM2: inactive below compare counting up, active above counting down.
// (R18) PWM reference changes only on result change or frozen-to-PWM switch.
// (R19) Lock level 3 with output channel blocks mode and preload writes.
// (R20) Preload on: accesses hit preload copy, moved to active on update.
// (R21) Preload off: compare writes take effect immediately.
// (R22) Software uses PWM without preload only in one-pulse mode.
// (R23) Fast enable: trigger edge acts as match, three-cycle latency.
// (R24) Fast disabled: normal compare operation, at least five-cycle latency.
// (R25) Direction field 00 means output; others mean input.
// (R26) Writing one to a flag leaves it unchanged; zero clears it.
module tcfe_top
	import tcfe_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int NCH = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [31:0] rd_data_out,
	input wire logic [CNT_W-1:0] core_counter_in,
	input wire tcfe_core_t core_in,
	input wire logic trigger_input_in,
	input wire logic filtered_external_trigger_in,
	input wire logic [NCH-1:0] capture_evt_in,
	input wire logic [NCH-1:0] far_match_in,
	input wire logic [NCH-1:0] far_is_output_in,
	output logic update_event_out,
	output logic trigger_event_out,
	output logic counter_reinit_out,
	output logic counter_load_reload_out,
	output logic prescaler_clear_out,
	output logic [NCH-1:0] chan_event_out,
	output logic [1:0] chan_reference_output_out
);
	if (CNT_W < 2 || CNT_W > 32 || NCH < 2 || NCH > 4)
		$error("tcfe_top: unsupported CNT_W or NCH");

	function automatic logic pwm_active(input logic [2:0] m, input logic dn,
			input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] r);
		logic p1;
		p1 = dn ? !(c > r) : (c < r);
		pwm_active = (m == TCFE_OM_PWM1) ? p1 : !p1;
	endfunction

	logic [15:0] ctrl_q, mode_q, flag_q, flag_d;
	logic [CNT_W-1:0] cmp_pre_q [2], cmp_act_q [2];
	logic [1:0] ref_q, prev_res_q, out_q;
	logic [2:0] trg_sync_q, etr_sync_q;
	logic trg_lvl_q, etr_lvl_q;
	logic wr_flag, wr_ev, wr_mode, upd_evt, trg_evt, trg_edge, ug;
	logic [NCH-1:0] is_out, ch_gen, cap_now, match, rd_cap;
	logic [1:0] wr_cmp, res_now;
	logic update_disable, update_request_source;

	assign update_disable = ctrl_q[TCFE_CTRL_UPDATE_DISABLE];
	assign update_request_source = ctrl_q[TCFE_CTRL_URS];
	assign wr_flag = wr_en_in && addr_in == TCFE_FLAG_OFS;
	assign wr_ev = wr_en_in && addr_in == TCFE_EVGEN_OFS;
	assign wr_mode = wr_en_in && addr_in == TCFE_MODE_OFS;
	assign wr_cmp[0] = wr_en_in && addr_in == TCFE_CMP1_OFS;
	assign wr_cmp[1] = wr_en_in && addr_in == TCFE_CMP2_OFS;
	assign ug = wr_ev && wr_data_in[TCFE_F_UPD];

	// Three-stage sync; a change counts once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			trg_sync_q <= 3'h0;
			etr_sync_q <= 3'h0;
			trg_lvl_q <= 1'b0;
			etr_lvl_q <= 1'b0;
		end else if (ce_in) begin
			trg_sync_q <= {trg_sync_q[1:0], trigger_input_in};
			etr_sync_q <= {etr_sync_q[1:0], filtered_external_trigger_in};
			if (trg_sync_q[1] == trg_sync_q[2])
				trg_lvl_q <= trg_sync_q[2];
			if (etr_sync_q[1] == etr_sync_q[2])
				etr_lvl_q <= etr_sync_q[2];
		end
	end

	logic trg_new;
	assign trg_new = (trg_sync_q[1] == trg_sync_q[2]) ? trg_sync_q[2]
		: trg_lvl_q;
	// Gating mode counts both edges, other modes the rising one
	assign trg_edge = core_in.gating_mode ? (trg_new != trg_lvl_q)
		: (trg_new && !trg_lvl_q); // R2
	assign trg_evt = trg_edge || (wr_ev && wr_data_in[TCFE_F_TRG]); // R8

	// Update event drives preload transfer whatever the request source
	assign upd_evt = !update_disable && (core_in.rep_wrap || ug
		|| core_in.trig_reinit); // R5 R11

	always_comb begin
		is_out = far_is_output_in;
		match = far_match_in & far_is_output_in;
		for (int i = 0; i < 2; i++) begin
			is_out[i] = mode_q[i*TCFE_M_CH_W+TCFE_M_DIR_LO +: 2]
				== TCFE_DIR_OUT; // R25
			match[i] = is_out[i] && core_counter_in == cmp_act_q[i];
		end
		for (int i = 0; i < NCH; i++) begin
			ch_gen[i] = wr_ev && wr_data_in[TCFE_F_CC0+i];
			cap_now[i] = !is_out[i] && (capture_evt_in[i] || ch_gen[i]);
		end
		rd_cap = '0;
		rd_cap[0] = rd_en_in && addr_in == TCFE_CMP1_OFS && !is_out[0];
		rd_cap[1] = rd_en_in && addr_in == TCFE_CMP2_OFS && !is_out[1];
	end

	// Clears first, then sets, so a same-cycle event survives its clear
	always_comb begin
		flag_d = flag_q;
		if (wr_flag)
			flag_d = flag_q & wr_data_in[15:0]; // R26
		for (int i = 0; i < NCH; i++) begin
			if (rd_cap[i])
				flag_d[TCFE_F_CC0+i] = 1'b0; // R4
			if (cap_now[i] && flag_q[TCFE_F_CC0+i])
				flag_d[TCFE_F_OVR0+i] = 1'b1; // R1 R10
			if (cap_now[i])
				flag_d[TCFE_F_CC0+i] = 1'b1; // R4 R10
			if (match[i] && !core_in.center_aligned)
				flag_d[TCFE_F_CC0+i] = 1'b1; // R3
			if (is_out[i] && ch_gen[i])
				flag_d[TCFE_F_CC0+i] = 1'b1; // R9
		end
		if (trg_evt)
			flag_d[TCFE_F_TRG] = 1'b1; // R2 R8
		if (!update_disable && (core_in.rep_wrap
				|| (!update_request_source && (ug || core_in.trig_reinit))))
			flag_d[TCFE_F_UPD] = 1'b1; // R5 R6 R7
		flag_d = flag_d & TCFE_FLAG_MASK;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			flag_q <= 16'h0000;
		else if (ce_in)
			flag_q <= flag_d;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			ctrl_q <= 16'h0000;
		else if (ce_in && wr_en_in && addr_in == TCFE_CTRL_OFS)
			ctrl_q <= wr_data_in[15:0];
	end

	// Lock level 3 freezes mode and preload of output channels
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			mode_q <= 16'h0000;
		else if (ce_in && wr_mode) begin
			for (int i = 0; i < 2; i++) begin
				for (int b = 0; b < TCFE_M_CH_W; b++) begin
					if (!(TCFE_M_LOCKED[b] && is_out[i]
							&& ctrl_q[TCFE_CTRL_LOCK_LO +: 2]
							== TCFE_LOCK_FULL)) // R19
						mode_q[i*TCFE_M_CH_W+b] <=
							wr_data_in[i*TCFE_M_CH_W+b];
				end
			end
		end
	end

	// Compare/capture registers of the two modelled channels
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 2; i++) begin
				cmp_pre_q[i] <= '0;
				cmp_act_q[i] <= '0;
			end
		end else if (ce_in) begin
			for (int i = 0; i < 2; i++) begin
				if (cap_now[i]) begin
					cmp_pre_q[i] <= core_counter_in; // R10
					cmp_act_q[i] <= core_counter_in;
				end else if (wr_cmp[i] && is_out[i]) begin
					cmp_pre_q[i] <= wr_data_in[CNT_W-1:0]; // R20
					if (!mode_q[i*TCFE_M_CH_W+TCFE_M_PE])
						cmp_act_q[i] <= wr_data_in[CNT_W-1:0]; // R21
				end else if (upd_evt && mode_q[i*TCFE_M_CH_W+TCFE_M_PE])
					cmp_act_q[i] <= cmp_pre_q[i]; // R20
			end
		end
	end

	// Output reference generation for channels one and two
	logic [2:0] om [2];
	logic [2:0] prev_om_q [2];
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			om[i] = mode_q[i*TCFE_M_CH_W+TCFE_M_MODE_LO +: 3];
			res_now[i] = pwm_active(om[i], core_in.count_down,
				core_counter_in, cmp_act_q[i]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ref_q <= 2'h0;
			prev_res_q <= 2'h0;
			for (int i = 0; i < 2; i++)
				prev_om_q[i] <= TCFE_OM_FROZEN;
		end else if (ce_in) begin
			for (int i = 0; i < 2; i++) begin
				prev_om_q[i] <= om[i];
				prev_res_q[i] <= res_now[i];
				case (om[i])
				TCFE_OM_FROZEN: ;
				TCFE_OM_SET: if (match[i]) ref_q[i] <= 1'b1; // R14
				TCFE_OM_CLR: if (match[i]) ref_q[i] <= 1'b0; // R14
				TCFE_OM_TOGGLE: if (match[i]) ref_q[i] <= !ref_q[i]; // R14
				TCFE_OM_LOW: ref_q[i] <= 1'b0; // R15
				TCFE_OM_HIGH: ref_q[i] <= 1'b1; // R15
				TCFE_OM_PWM1, TCFE_OM_PWM2: begin
					if (mode_q[i*TCFE_M_CH_W+TCFE_M_FE] && trg_edge)
						ref_q[i] <= (om[i] == TCFE_OM_PWM2)
							^ core_in.count_down; // R23
					else if (res_now[i] != prev_res_q[i]
							|| prev_om_q[i] == TCFE_OM_FROZEN)
						ref_q[i] <= res_now[i]; // R16 R17 R18 R24
				end
				default: ref_q[i] <= ref_q[i];
				endcase
			end
		end
	end

	// Reference held low while external trigger high and clear enabled
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			out_q <= 2'h0;
		else if (ce_in) begin
			for (int i = 0; i < 2; i++)
				out_q[i] <= ref_q[i] && !(etr_lvl_q
					&& mode_q[i*TCFE_M_CH_W+TCFE_M_CE]); // R13
		end
	end
	assign chan_reference_output_out = out_q;

	// Registered event pulses toward the counter core and request logic
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			update_event_out <= 1'b0;
			trigger_event_out <= 1'b0;
			counter_reinit_out <= 1'b0;
			counter_load_reload_out <= 1'b0;
			prescaler_clear_out <= 1'b0;
			chan_event_out <= '0;
		end else if (ce_in) begin
			update_event_out <= upd_evt;
			trigger_event_out <= trg_evt; // R8
			counter_reinit_out <= ug; // R11
			counter_load_reload_out <= ug && core_in.count_down
				&& !core_in.center_aligned; // R12
			prescaler_clear_out <= ug; // R11
			for (int i = 0; i < NCH; i++)
				chan_event_out[i] <= cap_now[i]
					|| (is_out[i] && (ch_gen[i] || (match[i]
					&& !core_in.center_aligned))); // R9
		end
	end

	// Generation register is write-only and always reads zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			rd_data_out <= 32'h0;
		else if (ce_in) begin
			rd_data_out <= 32'h0;
			if (rd_en_in) begin
				case (addr_in)
				TCFE_CTRL_OFS: rd_data_out <= {16'h0, ctrl_q};
				TCFE_FLAG_OFS: rd_data_out <= {16'h0, flag_q};
				TCFE_MODE_OFS: rd_data_out <= {16'h0, mode_q};
				TCFE_CMP1_OFS: rd_data_out <= 32'(cmp_pre_q[0]); // R20
				TCFE_CMP2_OFS: rd_data_out <= 32'(cmp_pre_q[1]);
				default: rd_data_out <= 32'h0;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in || !ce_in);

	chk_trig_flag_set: assert property (trg_evt |=> flag_q[TCFE_F_TRG]) // R2
		else $error("trigger flag not set");
	chk_upd_flag_wrap: assert property (core_in.rep_wrap && !update_disable // R5
		|=> flag_q[TCFE_F_UPD] && update_event_out)
		else $error("update flag not set on wrap");
	chk_upd_urs_block: assert property (ug && update_request_source && !core_in.rep_wrap // R6
		&& !flag_q[TCFE_F_UPD] && !(wr_flag) |=> !flag_q[TCFE_F_UPD]
		&& update_event_out == !update_disable)
		else $error("update flag set despite source select");
	chk_recap_set: assert property (cap_now[0] && flag_q[TCFE_F_CC0] // R1
		|=> flag_q[TCFE_F_OVR0])
		else $error("recapture flag missing");
	chk_cap_value: assert property (cap_now[0] // R10
		|=> cmp_pre_q[0] == $past(core_counter_in))
		else $error("capture value wrong");
	chk_one_keeps: assert property (wr_flag && flag_q[TCFE_F_TRG] // R26
		&& wr_data_in[TCFE_F_TRG] |=> flag_q[TCFE_F_TRG])
		else $error("flag lost on write of one");
	chk_force_low: assert property (om[0] == TCFE_OM_LOW // R15
		&& $past(om[0]) == TCFE_OM_LOW |=> ##1 !out_q[0])
		else $error("forced low mode not low");
	chk_etr_clear: assert property (etr_lvl_q && mode_q[TCFE_M_CE] // R13
		|=> !out_q[0])
		else $error("clear enable ignored");
	chk_nopre_now: assert property (wr_cmp[0] && is_out[0] // R21
		&& !mode_q[TCFE_M_PE] && !cap_now[0]
		|=> cmp_act_q[0] == $past(wr_data_in[CNT_W-1:0]))
		else $error("compare write not immediate");
	chk_lock_mode: assert property (wr_mode && is_out[0] // R19
		&& ctrl_q[TCFE_CTRL_LOCK_LO +: 2] == TCFE_LOCK_FULL
		|=> $stable(mode_q[TCFE_M_PE +: 4]))
		else $error("locked mode bits changed");
	chk_read_clear: assert property (rd_cap[0] && !cap_now[0] // R4
		|=> !flag_q[TCFE_F_CC0])
		else $error("capture read did not clear flag");
	chk_reload_down: assert property (ug && core_in.count_down // R11 R12
		&& !core_in.center_aligned |=> counter_load_reload_out
		&& counter_reinit_out && prescaler_clear_out)
		else $error("forced update outputs wrong");
	// Reference checks look ahead of the external clear gate
	chk_fast_force: assert property (om[0] == TCFE_OM_PWM2 // R23
		&& mode_q[TCFE_M_FE] && trg_edge && !core_in.count_down
		|=> ref_q[0])
		else $error("fast trigger did not force reference");
	chk_force_high: assert property (om[0] == TCFE_OM_HIGH // R15
		|=> ref_q[0])
		else $error("forced high mode not high");
	chk_toggle_match: assert property (om[0] == TCFE_OM_TOGGLE // R14
		&& match[0] |=> ref_q[0] != $past(ref_q[0]))
		else $error("toggle mode did not invert reference");
	chk_trig_pulse: assert property (trg_evt |=> trigger_event_out) // R8
		else $error("trigger event pulse missing");
	chk_upd_disabled: assert property (update_disable |=> !update_event_out) // R5
		else $error("update event while disabled");

	cov_pwm1_run: cover property (om[0] == TCFE_OM_PWM1 && $rose(ref_q[0]));
	cov_recapture: cover property (cap_now[1] && flag_q[TCFE_F_CC0+1]);
	cov_fast_trig: cover property (mode_q[TCFE_M_FE] && trg_edge
		&& om[0] == TCFE_OM_PWM2);
	cov_sw_update: cover property (ug && !update_request_source && !update_disable);
	cov_etr_clear: cover property (etr_lvl_q && mode_q[TCFE_M_CE] && ref_q[0]);
endmodule
`default_nettype wire

// ==== tcfe_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tcfe_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic [15:0] cnt = 16'h1000;
	tcfe_core_t core = '0;
	logic trg = 1'b0;
	logic etr = 1'b0;
	logic [3:0] cap = 4'h0;
	logic [3:0] fmatch = 4'h0;
	logic [3:0] fout = 4'h4;
	logic [31:0] rd_d;
	logic upd_o, trg_o, reinit_o, reload_o, psc_o;
	logic [3:0] chev;
	logic [1:0] ref_o;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] pm;
	logic [15:0] pc;
	tcfe_top tcfe_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.ce_in(ce), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_d),
		.core_counter_in(cnt), .core_in(core), .trigger_input_in(trg),
		.filtered_external_trigger_in(etr), .capture_evt_in(cap),
		.far_match_in(fmatch), .far_is_output_in(fout),
		.update_event_out(upd_o), .trigger_event_out(trg_o),
		.counter_reinit_out(reinit_o), .counter_load_reload_out(reload_o),
		.prescaler_clear_out(psc_o), .chan_event_out(chev),
		.chan_reference_output_out(ref_o));
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task automatic finish_test;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Bus strobes are one cycle; caller samples pulses right after return
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk(rd_d, exp);
	endtask
	task automatic pulse(input logic rp, input logic tr, input logic [3:0] c,
		input logic [3:0] f);
		@(posedge clk_in);
		core.rep_wrap <= rp;
		core.trig_reinit <= tr;
		cap <= c;
		fmatch <= f;
		@(posedge clk_in);
		core.rep_wrap <= 1'b0;
		core.trig_reinit <= 1'b0;
		cap <= 4'h0;
		fmatch <= 4'h0;
		#1;
	endtask
	// Counter equals v for exactly one cycle, so toggle fires once
	task automatic hit(input logic [15:0] v);
		@(posedge clk_in) cnt <= v;
		@(posedge clk_in) cnt <= 16'h1000;
		cyc(3);
	endtask
	task automatic clr;
		wr(TCFE_FLAG_OFS, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rchk(TCFE_FLAG_OFS, 32'h0);
		rchk(TCFE_MODE_OFS, 32'h0);
		rchk(8'h40, 32'h0);
		wr(TCFE_EVGEN_OFS, 32'h1);
		chk(32'({upd_o, reinit_o, psc_o, reload_o}), 32'hE);
		rchk(TCFE_EVGEN_OFS, 32'h0);
		rchk(TCFE_FLAG_OFS, 32'h1);
		wr(TCFE_FLAG_OFS, 32'hFFFF);
		rchk(TCFE_FLAG_OFS, 32'h1);
		clr();
		rchk(TCFE_FLAG_OFS, 32'h0);
		@(posedge clk_in) core.count_down <= 1'b1;
		wr(TCFE_EVGEN_OFS, 32'h1);
		chk(32'(reload_o), 32'h1);
		@(posedge clk_in) core.count_down <= 1'b0;
		wr(TCFE_EVGEN_OFS, 32'h1);
		chk(32'(reload_o), 32'h0);
		clr();
		wr(TCFE_CTRL_OFS, 32'h4);
		wr(TCFE_EVGEN_OFS, 32'h1);
		rchk(TCFE_FLAG_OFS, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(TCFE_CTRL_OFS, (i < 2) ? 32'h4 : ((i == 2) ? 32'h0 : 32'h2));
			pulse(i[0], !i[0], 4'h0, 4'h0);
			chk(32'(upd_o), (i < 3) ? 32'h1 : 32'h0);
			rchk(TCFE_FLAG_OFS, (i == 1 || i == 2) ? 32'h1 : 32'h0);
			clr();
		end
		wr(TCFE_CTRL_OFS, 32'h0);
		wr(TCFE_EVGEN_OFS, 32'h40);
		chk(32'(trg_o), 32'h1);
		rchk(TCFE_FLAG_OFS, 32'h40);
		clr();
		// Clock enable low: the generation write must leave no trace
		@(posedge clk_in) ce <= 1'b0;
		wr(TCFE_EVGEN_OFS, 32'h40);
		chk(32'(trg_o), 32'h0);
		@(posedge clk_in) ce <= 1'b1;
		rchk(TCFE_FLAG_OFS, 32'h0);
		@(posedge clk_in) trg <= 1'b1;
		cyc(8);
		rchk(TCFE_FLAG_OFS, 32'h40);
		clr();
		@(posedge clk_in) trg <= 1'b0;
		cyc(8);
		rchk(TCFE_FLAG_OFS, 32'h0);
		@(posedge clk_in) core.gating_mode <= 1'b1;
		@(posedge clk_in) trg <= 1'b1;
		cyc(8);
		clr();
		@(posedge clk_in) trg <= 1'b0;
		cyc(8);
		rchk(TCFE_FLAG_OFS, 32'h40);
		clr();
		wr(TCFE_EVGEN_OFS, 32'h2);
		chk(32'(chev), 32'h1);
		rchk(TCFE_FLAG_OFS, 32'h2);
		clr();
		pulse(1'b0, 1'b0, 4'h0, 4'h4);
		rchk(TCFE_FLAG_OFS, 32'h8);
		clr();
		wr(TCFE_MODE_OFS, 32'h1);
		@(posedge clk_in) cnt <= 16'h0ABC;
		pulse(1'b0, 1'b0, 4'h1, 4'h0);
		rchk(TCFE_FLAG_OFS, 32'h2);
		@(posedge clk_in) cnt <= 16'h0ABD;
		pulse(1'b0, 1'b0, 4'h1, 4'h0);
		rchk(TCFE_FLAG_OFS, 32'h202);
		rchk(TCFE_CMP1_OFS, 32'h0ABD);
		rchk(TCFE_FLAG_OFS, 32'h200);
		clr();
		rchk(TCFE_FLAG_OFS, 32'h0);
		@(posedge clk_in) cnt <= 16'h0777;
		wr(TCFE_EVGEN_OFS, 32'h2);
		wr(TCFE_EVGEN_OFS, 32'h2);
		rchk(TCFE_FLAG_OFS, 32'h202);
		rchk(TCFE_CMP1_OFS, 32'h0777);
		clr();
		@(posedge clk_in) cnt <= 16'h1000;
		wr(TCFE_MODE_OFS, 32'h0);
		wr(TCFE_CMP1_OFS, 32'h0100);
		for (int i = 0; i < 3; i++) begin
			wr(TCFE_MODE_OFS, i[0] ? 32'h50 : 32'h40);
			cyc(3);
			chk(32'(ref_o[0]), 32'(i[0]));
		end
		clr();
		for (int i = 0; i < 5; i++) begin
			wr(TCFE_MODE_OFS, 32'(i < 3 ? i + 1 : (i == 3 ? 3 : 0)) << 4);
			hit(16'h0100);
			chk(32'(ref_o[0]), (i == 0 || i == 2) ? 32'h1 : 32'h0);
		end
		rchk(TCFE_FLAG_OFS, 32'h2);
		clr();
		@(posedge clk_in) core.center_aligned <= 1'b1;
		hit(16'h0100);
		rchk(TCFE_FLAG_OFS, 32'h0);
		@(posedge clk_in) core.center_aligned <= 1'b0;
		wr(TCFE_MODE_OFS, 32'hD0);
		@(posedge clk_in) etr <= 1'b1;
		cyc(6);
		chk(32'(ref_o[0]), 32'h0);
		wr(TCFE_MODE_OFS, 32'h50);
		cyc(3);
		chk(32'(ref_o[0]), 32'h1);
		@(posedge clk_in) etr <= 1'b0;
		// Preload kept on in PWM, re-entered from frozen each time
		for (int i = 0; i < 6; i++) begin
			pm = (i == 0 || i == 1 || i == 4) ? 8'h68 : 8'h78;
			pc = (i == 0 || i == 2) ? 16'h0080 : 16'h0180;
			wr(TCFE_MODE_OFS, 32'h0);
			@(posedge clk_in) core.count_down <= (i > 3);
			@(posedge clk_in) cnt <= pc;
			wr(TCFE_MODE_OFS, 32'(pm));
			cyc(3);
			chk(32'(ref_o[0]), (i == 0 || i == 3 || i == 5) ? 32'h1 : 32'h0);
		end
		@(posedge clk_in) core.count_down <= 1'b0;
		@(posedge clk_in) cnt <= 16'h1000;
		wr(TCFE_MODE_OFS, 32'h0);
		@(posedge clk_in) cnt <= 16'h0080;
		wr(TCFE_MODE_OFS, 32'h78);
		@(posedge clk_in) trg <= 1'b1;
		cyc(6);
		chk(32'(ref_o[0]), 32'h0);
		wr(TCFE_MODE_OFS, 32'h7C);
		@(posedge clk_in) trg <= 1'b0;
		cyc(6);
		chk(32'(ref_o[0]), 32'h1);
		@(posedge clk_in) cnt <= 16'h1000;
		wr(TCFE_MODE_OFS, 32'h40);
		wr(TCFE_MODE_OFS, 32'h18);
		wr(TCFE_CMP1_OFS, 32'h0200);
		rchk(TCFE_CMP1_OFS, 32'h0200);
		hit(16'h0200);
		chk(32'(ref_o[0]), 32'h0);
		wr(TCFE_EVGEN_OFS, 32'h1);
		hit(16'h0200);
		chk(32'(ref_o[0]), 32'h1);
		wr(TCFE_MODE_OFS, 32'h20);
		wr(TCFE_CMP1_OFS, 32'h0300);
		hit(16'h0300);
		chk(32'(ref_o[0]), 32'h0);
		wr(TCFE_CTRL_OFS, 32'h300);
		wr(TCFE_MODE_OFS, 32'hE0E0);
		rchk(TCFE_MODE_OFS, 32'h80A0);
		finish_test();
	end
endmodule
`default_nettype wire
